/* logic/tbf_pkg.sv */
package tbf_pkg;

  // ----------------------------------------------------------------------
  // address layout of a received source address
  // ----------------------------------------------------------------------
  localparam int unsigned TBF_ADDR_W  = 8;
  localparam int unsigned TBF_CR_BIT  = 0;
  localparam int unsigned TBF_STA_LSB = 1;
  localparam logic        TBF_CR_CMD  = 1'b0;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int unsigned TBF_ID_W   = 8;
  localparam int unsigned TBF_NSTA   = 16;
  localparam int unsigned TBF_QDEPTH = 8;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] TBF_RST_SYNC = 2'h0;

  typedef enum logic [1:0]
  {
    TBF_PDU_DIA   = 2'h0,
    TBF_PDU_DRNR  = 2'h1,
    TBF_PDU_DRR   = 2'h2,
    TBF_PDU_OTHER = 2'h3
  } tbf_pdu_t;

  typedef enum logic [1:0]
  {
    TBF_CS_IDLE = 2'h0,
    TBF_CS_HOLD = 2'h1
  } tbf_cstate_t;

endpackage

/* logic/tbf_rtq.sv */
`timescale 1ns/1ps
module tbf_rtq
  import tbf_pkg::*;
#(
  parameter int unsigned NSTA  = TBF_NSTA,
  parameter int unsigned DEPTH = TBF_QDEPTH,
  parameter int unsigned IDW   = TBF_ID_W,
  parameter int unsigned SW    = $clog2(NSTA),
  parameter int unsigned CW    = $clog2(DEPTH + 1)
)
(
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            enq_valid,
  input  wire logic [IDW-1:0]  enq_id,
  input  wire logic [NSTA-1:0] enq_dest,
  output logic                 enq_ready,
  input  wire logic            prune_valid,
  input  wire logic [SW-1:0]   prune_sta,
  input  wire logic            ack_valid,
  input  wire logic [IDW-1:0]  ack_id,
  input  wire logic [SW-1:0]   ack_sta,
  output logic                 ack_hit,
  output logic [CW-1:0]        count
);

  typedef struct packed
  {
    logic [DEPTH-1:0]           vld;
    logic [DEPTH-1:0][IDW-1:0]  id;
    logic [DEPTH-1:0][NSTA-1:0] dest;
    logic                       hit;
    logic [CW-1:0]              cnt;
  } tbf_rtq_state_t;

  tbf_rtq_state_t st;
  tbf_rtq_state_t next_st;

  function automatic logic [CW-1:0] tbf_ones(input logic [DEPTH-1:0] v);
    logic [CW-1:0] n;
    n = '0;
    for (int i = 0; i < DEPTH; i++)
    begin
      n = n + CW'(v[i]);
    end
    return n;
  endfunction

  // a slot freed this cycle is reused only next cycle, keeping the
  // free search off the prune and ack paths
  assign enq_ready = ~&st.vld;
  assign ack_hit   = st.hit;
  assign count     = st.cnt;

  always_comb
  begin
    logic placed;
    placed  = 1'b0;
    next_st = st;
    next_st.hit = 1'b0;
    for (int i = 0; i < DEPTH; i++)
    begin
      if (st.vld[i])
      begin
        if (prune_valid)
        begin
          next_st.dest[i][prune_sta] = 1'b0;
        end
        if (ack_valid && st.id[i] == ack_id && st.dest[i][ack_sta])
        begin
          next_st.dest[i][ack_sta] = 1'b0;
          next_st.hit = 1'b1;
        end
        if (next_st.dest[i] == '0)
        begin
          next_st.vld[i] = 1'b0;
        end
      end
      else if (enq_valid && !placed && enq_dest != '0)
      begin
        placed = 1'b1;
        next_st.vld[i]  = 1'b1;
        next_st.id[i]   = enq_id;
        next_st.dest[i] = enq_dest;
      end
    end
    next_st.cnt = tbf_ones(next_st.vld);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

/* logic/tbf_tracker.sv */
// Functional notes
// - DRNR command marks sender busy and stops DIA sends to it.
// - busy station may stay in multi-destination PDU if another is free.
// - received DRNR never alters our own quiet mode.
// - marking busy nulls that station from every retransmission entry.
// - DRR command from station clears its busy mark.
// - busy after own DRNR command: answer with DRNR response unless quiet.
// - DRNR response: find outstanding DIA entry by its id.
// - remove DRNR responder from that entry's destinations if present.
// - any DRR goes out only with quiet off and a trigger.
// - trigger: busy ended after our DRNR command.
// - trigger: not busy and received DIA asking acknowledgment.
// - trigger: explicit user request, accepted only with quiet off.
// - DRR response deletes responder from matching DIA entry.
// - source address first bit gives command/response; individual only.
`timescale 1ns/1ps
module tbf_tracker
  import tbf_pkg::*;
#(
  parameter int unsigned NSTA  = TBF_NSTA,
  parameter int unsigned DEPTH = TBF_QDEPTH,
  parameter int unsigned IDW   = TBF_ID_W,
  parameter int unsigned SW    = $clog2(NSTA),
  parameter int unsigned CW    = $clog2(DEPTH + 1)
)
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  quiet_mode,
  input  wire logic                  local_busy,
  input  wire logic                  rx_valid,
  input  wire tbf_pdu_t              rx_kind,
  input  wire logic [TBF_ADDR_W-1:0] rx_src,
  input  wire logic [IDW-1:0]        rx_id,
  input  wire logic                  rx_ack_req,
  input  wire logic                  user_drr_req,
  input  wire logic                  dia_req,
  input  wire logic [IDW-1:0]        dia_id,
  input  wire logic [NSTA-1:0]       dia_dest,
  output logic                       dia_go,
  output logic [IDW-1:0]             dia_go_id,
  output logic [NSTA-1:0]            dia_go_dest,
  output logic                       dia_drop,
  output logic                       ctl_valid,
  input  wire logic                  ctl_ready,
  output tbf_pdu_t                   ctl_kind,
  output logic                       ctl_rsp,
  output logic [SW-1:0]              ctl_sta,
  output logic [IDW-1:0]             ctl_id,
  output logic [NSTA-1:0]            sta_busy,
  output logic [CW-1:0]              rtq_count,
  output logic                       rtq_ack
);

  localparam int unsigned FW = TBF_ADDR_W - TBF_STA_LSB;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    logic [NSTA-1:0] busy;
    logic            busy_q;
    logic            drnr_sent;
    logic            pend_drnr;
    logic            pend_drr;
    logic            pend_rsp;
    tbf_pdu_t        rsp_kind;
    logic [SW-1:0]   rsp_sta;
    logic [IDW-1:0]  rsp_id;
    tbf_cstate_t     cstate;
    logic            ctl_valid;
    tbf_pdu_t        ctl_kind;
    logic            ctl_rsp;
    logic [SW-1:0]   ctl_sta;
    logic [IDW-1:0]  ctl_id;
    logic            dia_go;
    logic [IDW-1:0]  dia_go_id;
    logic [NSTA-1:0] dia_go_dest;
    logic            dia_drop;
  } tbf_state_t;

  tbf_state_t st;
  tbf_state_t next_st;
  logic [1:0] rst_sync;
  logic       rst_int_n;

  function automatic logic tbf_multi(input logic [NSTA-1:0] m);
    return |(m & (m - NSTA'(1)));
  endfunction

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync <= TBF_RST_SYNC;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_int_n = rst_sync[1];

  // ----------------------------------------------------------------------
  // receive decode
  // ----------------------------------------------------------------------
  logic [FW-1:0] src_field;
  logic [SW-1:0] src_sta;
  logic          src_cmd;
  logic          rx_ok;
  logic          drnr_cmd_rx;
  logic          drr_cmd_rx;
  logic          ack_rx;

  assign src_field = rx_src[TBF_ADDR_W-1:TBF_STA_LSB];
  assign src_sta   = src_field[SW-1:0];
  assign src_cmd   = (rx_src[TBF_CR_BIT] == TBF_CR_CMD);
  // group or unknown sources fall outside the table and are ignored
  assign rx_ok     = rx_valid && (src_field < FW'(NSTA));
  assign drnr_cmd_rx = rx_ok && src_cmd && rx_kind == TBF_PDU_DRNR;
  assign drr_cmd_rx  = rx_ok && src_cmd && rx_kind == TBF_PDU_DRR;
  assign ack_rx = rx_ok && !src_cmd &&
                  (rx_kind == TBF_PDU_DRNR || rx_kind == TBF_PDU_DRR);

  // ----------------------------------------------------------------------
  // transmit gating
  // ----------------------------------------------------------------------
  logic [NSTA-1:0] free_dest;
  logic [NSTA-1:0] sel_dest;
  logic [NSTA-1:0] prune_mask;
  logic [NSTA-1:0] enq_dest;
  logic            enq_ready;
  logic            enq_valid;

  assign free_dest = dia_dest & ~st.busy;
  assign sel_dest  = (tbf_multi(dia_dest) && free_dest != '0) ?
                     dia_dest : free_dest;
  // an entry queued in the same cycle as a DRNR must be pruned too
  assign prune_mask = drnr_cmd_rx ? (NSTA'(1) << src_sta) : '0;
  assign enq_dest   = sel_dest & ~prune_mask;
  assign enq_valid  = dia_req && sel_dest != '0 && enq_ready;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.busy_q   = local_busy;
    next_st.dia_go   = 1'b0;
    next_st.dia_drop = 1'b0;

    if (drnr_cmd_rx)
    begin
      next_st.busy[src_sta] = 1'b1;
    end
    if (drr_cmd_rx)
    begin
      next_st.busy[src_sta] = 1'b0;
    end

    if (dia_req)
    begin
      if (enq_valid)
      begin
        next_st.dia_go      = 1'b1;
        next_st.dia_go_id   = dia_id;
        next_st.dia_go_dest = sel_dest;
      end
      else
      begin
        next_st.dia_drop = 1'b1;
      end
    end

    // emitter: clears come first so a new trigger in the same cycle wins
    case (st.cstate)
      TBF_CS_IDLE:
      begin
        if (st.pend_drnr)
        begin
          next_st.pend_drnr = 1'b0;
          next_st.ctl_valid = 1'b1;
          next_st.ctl_kind  = TBF_PDU_DRNR;
          next_st.ctl_rsp   = 1'b0;
          next_st.ctl_sta   = '0;
          next_st.ctl_id    = '0;
          next_st.cstate    = TBF_CS_HOLD;
        end
        else if (st.pend_rsp && !quiet_mode)
        begin
          next_st.pend_rsp  = 1'b0;
          next_st.ctl_valid = 1'b1;
          next_st.ctl_kind  = st.rsp_kind;
          next_st.ctl_rsp   = 1'b1;
          next_st.ctl_sta   = st.rsp_sta;
          next_st.ctl_id    = st.rsp_id;
          next_st.cstate    = TBF_CS_HOLD;
        end
        else if (st.pend_drr && !quiet_mode)
        begin
          next_st.pend_drr  = 1'b0;
          next_st.ctl_valid = 1'b1;
          next_st.ctl_kind  = TBF_PDU_DRR;
          next_st.ctl_rsp   = 1'b0;
          next_st.ctl_sta   = '0;
          next_st.ctl_id    = '0;
          next_st.cstate    = TBF_CS_HOLD;
        end
      end
      TBF_CS_HOLD:
      begin
        if (ctl_ready)
        begin
          next_st.ctl_valid = 1'b0;
          next_st.cstate    = TBF_CS_IDLE;
          if (st.ctl_kind == TBF_PDU_DRNR && !st.ctl_rsp)
          begin
            next_st.drnr_sent = 1'b1;
          end
        end
      end
      default:
      begin
        next_st.ctl_valid = 1'b0;
        next_st.cstate    = TBF_CS_IDLE;
      end
    endcase

    if (quiet_mode)
    begin
      next_st.pend_drr = 1'b0;
      next_st.pend_rsp = 1'b0;
    end

    if (local_busy && !st.busy_q)
    begin
      next_st.pend_drnr = 1'b1;
    end
    if (!local_busy && st.busy_q)
    begin
      next_st.pend_drnr = 1'b0;
      if (st.drnr_sent && !quiet_mode)
      begin
        next_st.pend_drr = 1'b1;
      end
      next_st.drnr_sent = 1'b0;
    end

    if (user_drr_req && !quiet_mode)
    begin
      next_st.pend_drr = 1'b1;
    end

    // one response slot; a newer trigger replaces an unsent one
    if (rx_ok && src_cmd && rx_kind == TBF_PDU_DIA && rx_ack_req &&
        !quiet_mode)
    begin
      if (local_busy && st.drnr_sent)
      begin
        next_st.pend_rsp = 1'b1;
        next_st.rsp_kind = TBF_PDU_DRNR;
        next_st.rsp_sta  = src_sta;
        next_st.rsp_id   = rx_id;
      end
      else if (!local_busy)
      begin
        next_st.pend_rsp = 1'b1;
        next_st.rsp_kind = TBF_PDU_DRR;
        next_st.rsp_sta  = src_sta;
        next_st.rsp_id   = rx_id;
      end
    end
    // quiet mode is an input only, no received PDU writes it
  end

  always_ff @(posedge clk_sys or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // retransmission queue
  // ----------------------------------------------------------------------
  tbf_rtq #(
    .NSTA  (NSTA),
    .DEPTH (DEPTH),
    .IDW   (IDW),
    .SW    (SW),
    .CW    (CW)
  ) u_rtq (
    .clk_sys     (clk_sys),
    .rst_n       (rst_int_n),
    .enq_valid   (enq_valid),
    .enq_id      (dia_id),
    .enq_dest    (enq_dest),
    .enq_ready   (enq_ready),
    .prune_valid (drnr_cmd_rx),
    .prune_sta   (src_sta),
    .ack_valid   (ack_rx),
    .ack_id      (rx_id),
    .ack_sta     (src_sta),
    .ack_hit     (rtq_ack),
    .count       (rtq_count)
  );

  assign dia_go      = st.dia_go;
  assign dia_go_id   = st.dia_go_id;
  assign dia_go_dest = st.dia_go_dest;
  assign dia_drop    = st.dia_drop;
  assign ctl_valid   = st.ctl_valid;
  assign ctl_kind    = st.ctl_kind;
  assign ctl_rsp     = st.ctl_rsp;
  assign ctl_sta     = st.ctl_sta;
  assign ctl_id      = st.ctl_id;
  assign sta_busy    = st.busy;

endmodule

/* bench/tbf_tracker_checker.sv */
`timescale 1ns/1ps
module tbf_tracker_checker
  import tbf_pkg::*;
#(
  parameter int unsigned NSTA  = TBF_NSTA,
  parameter int unsigned DEPTH = TBF_QDEPTH,
  parameter int unsigned SW    = $clog2(NSTA),
  parameter int unsigned CW    = $clog2(DEPTH + 1)
)
(
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  quiet_mode,
  input wire logic                  local_busy,
  input wire logic                  rx_valid,
  input wire tbf_pdu_t              rx_kind,
  input wire logic [TBF_ADDR_W-1:0] rx_src,
  input wire logic                  user_drr_req,
  input wire logic                  dia_req,
  input wire logic [NSTA-1:0]       dia_dest,
  input wire logic                  dia_go,
  input wire logic [NSTA-1:0]       dia_go_dest,
  input wire logic                  dia_drop,
  input wire logic                  ctl_valid,
  input wire logic                  ctl_ready,
  input wire tbf_pdu_t              ctl_kind,
  input wire logic                  ctl_rsp,
  input wire logic [NSTA-1:0]       sta_busy,
  input wire logic [CW-1:0]         rtq_count,
  input wire logic                  rtq_ack
);
  logic [SW-1:0] sta;
  logic          known;
  logic          cmd;

  // unknown stations are ignored, so only known ones arm the checks
  assign sta   = rx_src[TBF_STA_LSB +: SW];
  assign known = rx_valid && (rx_src[TBF_ADDR_W-1:TBF_STA_LSB] < NSTA);
  assign cmd   = rx_src[TBF_CR_BIT] == TBF_CR_CMD;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_BUSY_SET: assert property (
    known && cmd && rx_kind == TBF_PDU_DRNR |=> sta_busy[$past(sta)])
    else $error("busy mark not set");
  AST_BUSY_CLR: assert property (
    known && cmd && rx_kind == TBF_PDU_DRR |=> !sta_busy[$past(sta)])
    else $error("busy mark not cleared");
  AST_ALL_BUSY: assert property (
    dia_req && (dia_dest & ~sta_busy) == '0 |=> dia_drop && !dia_go)
    else $error("dia to busy stations not refused");
  AST_MULTI_KEEP: assert property (
    dia_req && $countones(dia_dest) > 1 && (dia_dest & ~sta_busy) != '0
    && rtq_count < DEPTH |=> dia_go && dia_go_dest == $past(dia_dest))
    else $error("multi destination set not kept");
  AST_SINGLE_FREE: assert property (
    dia_go && $countones(dia_go_dest) == 1
    |-> (dia_go_dest & $past(sta_busy)) == '0)
    else $error("single dia sent to busy station");
  AST_QUIET_GATE: assert property (
    $rose(ctl_valid) && (ctl_kind == TBF_PDU_DRR || ctl_rsp)
    |-> !$past(quiet_mode))
    else $error("drr or response while quiet");
  AST_CTL_HOLD: assert property (
    ctl_valid && !ctl_ready
    |=> ctl_valid && $stable(ctl_kind) && $stable(ctl_rsp))
    else $error("control pdu not held");
  AST_CTL_DROP: assert property (
    ctl_valid && ctl_ready |=> !ctl_valid)
    else $error("control pdu not released");
  AST_USER_DRR: assert property (
    user_drr_req && !quiet_mode && !ctl_valid && !local_busy
    |-> ##[2:40] ctl_valid && ctl_kind == TBF_PDU_DRR)
    else $error("user drr request lost");
  AST_ACK_CAUSE: assert property (
    rtq_ack |-> $past(known && !cmd && rx_kind inside
    {TBF_PDU_DRNR, TBF_PDU_DRR}))
    else $error("ack without response pdu");

  CV_BUSY: cover property (known && cmd && rx_kind == TBF_PDU_DRNR);
  CV_ACK: cover property (rtq_ack);
  CV_RSP: cover property (ctl_valid && ctl_ready && ctl_rsp);
endmodule

bind tbf_tracker tbf_tracker_checker #(
  .NSTA(NSTA),
  .DEPTH(DEPTH),
  .SW(SW),
  .CW(CW)
) i_chk (.*);

/* bench/tbf_remote.sv */
`timescale 1ns/1ps
module tbf_remote
  import tbf_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       slow,
  input  wire logic       ctl_valid,
  input  wire tbf_pdu_t   ctl_kind,
  input  wire logic       ctl_rsp,
  input  wire logic [3:0] ctl_sta,
  input  wire logic [7:0] ctl_id,
  output logic            ctl_ready,
  output logic            rx_valid,
  output tbf_pdu_t        rx_kind,
  output logic [7:0]      rx_src,
  output logic [7:0]      rx_id,
  output logic            rx_ack_req
);
  int         got_n = 0;
  tbf_pdu_t   got_kind;
  logic       got_rsp;
  logic [3:0] got_sta;
  logic [7:0] got_id;

  initial
  begin
    ctl_ready  = 1'b1;
    rx_valid   = 1'b0;
    rx_kind    = TBF_PDU_OTHER;
    rx_src     = 8'h00;
    rx_id      = 8'h00;
    rx_ack_req = 1'b0;
  end

  // slow mode stalls every other cycle to exercise the hold
  always @(posedge clk_sys)
  begin
    if (ctl_valid && ctl_ready)
    begin
      got_n    <= got_n + 1;
      got_kind <= ctl_kind;
      got_rsp  <= ctl_rsp;
      got_sta  <= ctl_sta;
      got_id   <= ctl_id;
    end
    ctl_ready <= slow ? ~ctl_ready : 1'b1;
  end

  task automatic send(input tbf_pdu_t k, input logic [7:0] src,
                      input logic [7:0] id, input logic ack);
    @(posedge clk_sys);
    rx_valid   <= 1'b1;
    rx_kind    <= k;
    rx_src     <= src;
    rx_id      <= id;
    rx_ack_req <= ack;
    @(posedge clk_sys);
    rx_valid   <= 1'b0;
    rx_src     <= ~src;
    rx_id      <= ~id;
    rx_ack_req <= ~ack;
  endtask
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module testbench;
  import tbf_pkg::*;
  logic        clk_sys      = 1'b0;
  logic        rst_n        = 1'b0;
  logic        quiet_mode   = 1'b0;
  logic        local_busy   = 1'b0;
  logic        user_drr_req = 1'b0;
  logic        dia_req      = 1'b0;
  logic [7:0]  dia_id       = 8'h00;
  logic [15:0] dia_dest     = 16'h0000;
  logic        slow         = 1'b0;
  logic        rx_valid, rx_ack_req, dia_go, dia_drop, ctl_valid;
  logic        ctl_ready, ctl_rsp, rtq_ack;
  tbf_pdu_t    rx_kind, ctl_kind;
  logic [7:0]  rx_src, rx_id, dia_go_id, ctl_id;
  logic [15:0] dia_go_dest, sta_busy;
  logic [3:0]  ctl_sta, rtq_count;
  int          n_fail   = 0;
  int          compares = 0;

  always #2.5 clk_sys = ~clk_sys;

  tbf_tracker i_dut (.*);
  tbf_remote  i_rem (.*);

  // --------
  // helpers
  // --------
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic dia(input logic [7:0] id, input logic [15:0] dest,
                     input logic [15:0] exp);
    @(posedge clk_sys);
    dia_req  <= 1'b1;
    dia_id   <= id;
    dia_dest <= dest;
    @(posedge clk_sys);
    dia_req  <= 1'b0;
    #1;
    `CHK(dia_go, exp != 16'h0000);
    `CHK(dia_drop, exp == 16'h0000);
    if (exp != 16'h0000)
    begin
      `CHK(dia_go_dest, exp);
      `CHK(dia_go_id, id);
    end
  endtask

  task automatic rx(input tbf_pdu_t k, input logic [7:0] src,
                    input logic [7:0] id, input logic ack);
    i_rem.send(k, src, id, ack);
    #1;
  endtask

  task automatic user();
    @(posedge clk_sys);
    user_drr_req <= 1'b1;
    @(posedge clk_sys);
    user_drr_req <= 1'b0;
  endtask

  // waits are bounded; a lost pdu ends the run
  task automatic ctl(input tbf_pdu_t k, input logic r,
                     input logic [3:0] s, input logic [7:0] id);
    int n0;
    n0 = i_rem.got_n;
    for (int i = 0; i < 40 && i_rem.got_n == n0; i++)
      @(posedge clk_sys);
    #1;
    if (i_rem.got_n == n0)
    begin
      n_fail++;
      $display("[ERR] %0t control pdu timed out", $time);
      summarize();
    end
    else
    begin
      `CHK(i_rem.got_kind, k);
      `CHK(i_rem.got_rsp, r);
      `CHK(i_rem.got_sta, s);
      `CHK(i_rem.got_id, id);
    end
  endtask

  task automatic none();
    int n0;
    n0 = i_rem.got_n;
    repeat (12) @(posedge clk_sys);
    #1;
    `CHK(i_rem.got_n, n0);
  endtask

  // --------
  // scenarios
  // --------
  task automatic s_busy();
    dia(8'h01, 16'h0008, 16'h0008);
    `CHK(rtq_count, 4'h1);
    rx(TBF_PDU_DRNR, 8'h06, 8'h00, 1'b0);
    `CHK(sta_busy, 16'h0008);
    `CHK(rtq_count, 4'h0);
    rx(TBF_PDU_DRNR, 8'h40, 8'h00, 1'b0);
    `CHK(sta_busy, 16'h0008);
    dia(8'h02, 16'h0008, 16'h0000);
    dia(8'h03, 16'h000c, 16'h000c);
    rx(TBF_PDU_DRR, 8'h06, 8'h00, 1'b0);
    `CHK(sta_busy, 16'h0000);
    dia(8'h05, 16'h0008, 16'h0008);
    `CHK(rtq_count, 4'h2);
  endtask

  task automatic s_ack();
    rx(TBF_PDU_DRNR, 8'h07, 8'h03, 1'b0);
    `CHK(rtq_ack, 1'b1);
    rx(TBF_PDU_DRNR, 8'h07, 8'h03, 1'b0);
    `CHK(rtq_ack, 1'b0);
    rx(TBF_PDU_DRR, 8'h05, 8'h05, 1'b0);
    `CHK(rtq_ack, 1'b0);
    rx(TBF_PDU_DRR, 8'h07, 8'h05, 1'b0);
    `CHK(rtq_ack, 1'b1);
  endtask

  task automatic s_ctl();
    @(posedge clk_sys);
    slow <= 1'b1;
    user();
    ctl(TBF_PDU_DRR, 1'b0, 4'h0, 8'h00);
    @(posedge clk_sys);
    quiet_mode <= 1'b1;
    user();
    none();
    @(posedge clk_sys);
    quiet_mode <= 1'b0;
    local_busy <= 1'b1;
    ctl(TBF_PDU_DRNR, 1'b0, 4'h0, 8'h00);
    rx(TBF_PDU_DIA, 8'h0a, 8'h21, 1'b1);
    ctl(TBF_PDU_DRNR, 1'b1, 4'h5, 8'h21);
    @(posedge clk_sys);
    local_busy <= 1'b0;
    ctl(TBF_PDU_DRR, 1'b0, 4'h0, 8'h00);
    rx(TBF_PDU_DIA, 8'h0a, 8'h24, 1'b0);
    none();
    rx(TBF_PDU_DIA, 8'h0a, 8'h22, 1'b1);
    ctl(TBF_PDU_DRR, 1'b1, 4'h5, 8'h22);
    @(posedge clk_sys);
    quiet_mode <= 1'b1;
    rx(TBF_PDU_DIA, 8'h0a, 8'h23, 1'b1);
    none();
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    s_busy();
    s_ack();
    s_ctl();
    summarize();
  end
endmodule
